// *** src/config_status_mirror.sv ***
`timescale 1ns/100ps
// What this block does
// - per function, 8-bit bus number from config writes
// - per function, 5-bit device number from config writes
// - bus number output is informational only
// - device number unused while alternative routing enabled
// - per function memory space enable mirror
// - per function bus master enable mirror
// - per function virtual function memory enable mirror
// - per function 16-bit enabled virtual function count
// - payload limit: function 0 alone, else minimum
// - read request limit: function 0 alone, else minimum
// - bit n mirrors wide tag enable, bit 8
// - bit n mirrors timeout disable, bit 4
// - bit n mirrors atomic requester enable
// - packed 2-bit steering tag mode, function 0 lowest
// - bit n mirrors hint requester enable, bit 8
// - packed 5-bit translation unit size slices
// - bit n mirrors translation enable, bit 31
module config_status_mirror (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic cfg_wr_valid_i,
  input wire logic [config_status_mirror_pkg::FN_W-1:0] cfg_wr_fn_i,
  input wire logic [config_status_mirror_pkg::IDX_W-1:0] cfg_wr_index_i,
  input wire logic [3:0] cfg_wr_be_i,
  input wire logic [31:0] cfg_wr_data_i,
  input wire logic [config_status_mirror_pkg::BUS_W-1:0] cfg_wr_bus_i,
  input wire logic [config_status_mirror_pkg::DEV_W-1:0] cfg_wr_dev_i,
  input wire logic ari_on_i,
  input wire logic [2:0] fn_count_i,
  output logic [config_status_mirror_pkg::NUM_FN*config_status_mirror_pkg::BUS_W-1:0]
    assigned_bus_id_o,
  output logic [config_status_mirror_pkg::NUM_FN*config_status_mirror_pkg::DEV_W-1:0]
    assigned_dev_id_o,
  output logic [config_status_mirror_pkg::NUM_FN-1:0] phys_fn_memory_decode_on_o,
  output logic [config_status_mirror_pkg::NUM_FN-1:0] phys_fn_initiator_allowed_o,
  output logic [config_status_mirror_pkg::NUM_FN-1:0] virt_fn_memory_decode_on_o,
  output logic [config_status_mirror_pkg::NUM_FN*config_status_mirror_pkg::NUMVF_W-1:0]
    enabled_virtual_fn_count_o,
  output logic [config_status_mirror_pkg::SIZE_W-1:0] payload_limit_o,
  output logic [config_status_mirror_pkg::SIZE_W-1:0] read_request_limit_o,
  output logic [config_status_mirror_pkg::NUM_FN-1:0] wide_tag_allowed_o,
  output logic [config_status_mirror_pkg::NUM_FN-1:0] response_timer_off_o,
  output logic [config_status_mirror_pkg::NUM_FN-1:0] atomic_issue_allowed_o,
  output logic [config_status_mirror_pkg::NUM_FN*config_status_mirror_pkg::MODE_W-1:0]
    steering_tag_mode_sel_o,
  output logic [config_status_mirror_pkg::NUM_FN-1:0] processing_hint_issue_on_o,
  output logic [config_status_mirror_pkg::NUM_FN*config_status_mirror_pkg::UNIT_W-1:0]
    translation_unit_size_o,
  output logic [config_status_mirror_pkg::NUM_FN-1:0] address_translation_on_o
);

  localparam int NF = config_status_mirror_pkg::NUM_FN;
  localparam int SW = config_status_mirror_pkg::SIZE_W;
  localparam int FW = config_status_mirror_pkg::FN_W;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // byte lane enable covering a given bit of the written dword
  function automatic logic lane_on(input logic [3:0] be, input logic [4:0] pos);
    lane_on = be[pos[4:3]];
  endfunction

  // smaller of two size codes; a smaller code stands for a smaller size
  function automatic logic [SW-1:0] smaller(input logic [SW-1:0] a, input logic [SW-1:0] b);
    smaller = (b < a) ? b : a;
  endfunction

  // ----------------------------------------------------------------------
  // next values of the per-function fields
  // ----------------------------------------------------------------------
  logic [NF*config_status_mirror_pkg::BUS_W-1:0] bus_next;
  logic [NF*config_status_mirror_pkg::DEV_W-1:0] dev_next;
  logic [NF-1:0] mem_next;
  logic [NF-1:0] init_next;
  logic [NF-1:0] vmem_next;
  logic [NF*config_status_mirror_pkg::NUMVF_W-1:0] numvf_next;
  logic [NF-1:0][SW-1:0] payload_reg;
  logic [NF-1:0][SW-1:0] payload_next;
  logic [NF-1:0][SW-1:0] rdreq_reg;
  logic [NF-1:0][SW-1:0] rdreq_next;
  logic [NF-1:0] tag_next;
  logic [NF-1:0] timer_next;
  logic [NF-1:0] atomic_next;
  logic [NF*config_status_mirror_pkg::MODE_W-1:0] mode_next;
  logic [NF-1:0] hint_next;
  logic [NF*config_status_mirror_pkg::UNIT_W-1:0] unit_next;
  logic [NF-1:0] xlat_next;
  logic [NF-1:0][SW-1:0] payload_min;
  logic [NF-1:0][SW-1:0] rdreq_min;

  // a count of zero still means function 0 alone
  wire [2:0] fn_used = (fn_count_i == 3'h0) ? 3'h1 : fn_count_i;
  // bit positions as 5-bit numbers for the byte lane lookup
  wire [4:0] p_mem = 5'(config_status_mirror_pkg::CMD_MEM_BIT);
  wire [4:0] p_init = 5'(config_status_mirror_pkg::CMD_INIT_BIT);
  wire [4:0] p_pay = 5'(config_status_mirror_pkg::DC_PAYLOAD_LSB);
  wire [4:0] p_tag = 5'(config_status_mirror_pkg::DC_WIDE_TAG_BIT);
  wire [4:0] p_rdq = 5'(config_status_mirror_pkg::DC_RDREQ_LSB);
  wire [4:0] p_tmr = 5'(config_status_mirror_pkg::DC2_TIMER_OFF_BIT);
  wire [4:0] p_atm = 5'(config_status_mirror_pkg::DC2_ATOMIC_BIT);
  wire [4:0] p_vmem = 5'(config_status_mirror_pkg::VIRT_MEM_BIT);
  wire [4:0] p_nvf = 5'(config_status_mirror_pkg::NUMVF_LSB);
  wire [4:0] p_mode = 5'(config_status_mirror_pkg::HINT_MODE_LSB);
  wire [4:0] p_hint = 5'(config_status_mirror_pkg::HINT_EN_BIT);
  wire [4:0] p_unit = 5'(config_status_mirror_pkg::XLAT_UNIT_LSB);
  wire [4:0] p_xlat = 5'(config_status_mirror_pkg::XLAT_EN_BIT);

  genvar f;
  generate
    for (f = 0; f < NF; f = f + 1)
    begin : g_fn
      localparam int BW = config_status_mirror_pkg::BUS_W;
      localparam int DW = config_status_mirror_pkg::DEV_W;
      localparam int VW = config_status_mirror_pkg::NUMVF_W;
      localparam int MW = config_status_mirror_pkg::MODE_W;
      localparam int UW = config_status_mirror_pkg::UNIT_W;
      // write decode for this function
      wire hit = cfg_wr_valid_i && (cfg_wr_fn_i == FW'(f));
      wire hit_cmd = hit && (cfg_wr_index_i == config_status_mirror_pkg::IDX_CMD);
      wire hit_dc = hit && (cfg_wr_index_i == config_status_mirror_pkg::IDX_DEV_CTL);
      wire hit_dc2 = hit && (cfg_wr_index_i == config_status_mirror_pkg::IDX_DEV_CTL2);
      wire hit_vc = hit && (cfg_wr_index_i == config_status_mirror_pkg::IDX_VIRT_CTL);
      wire hit_nvf = hit && (cfg_wr_index_i == config_status_mirror_pkg::IDX_VIRT_NUMVF);
      wire hit_hint = hit && (cfg_wr_index_i == config_status_mirror_pkg::IDX_HINT_CTL);
      wire hit_xlat = hit && (cfg_wr_index_i == config_status_mirror_pkg::IDX_XLAT_CTL);
      // the enabled count spans two bytes, each with its own enable
      wire nvf_lo = hit_nvf && lane_on(cfg_wr_be_i, p_nvf);
      wire nvf_hi = hit_nvf && lane_on(cfg_wr_be_i, p_nvf + 5'h08);

      // the routing id of any config write to this function carries its numbers;
      // the device field means nothing while alternative routing is on, so it holds
      assign bus_next[f*BW +: BW] = hit ? cfg_wr_bus_i : assigned_bus_id_o[f*BW +: BW];
      assign dev_next[f*DW +: DW] = (hit && !ari_on_i) ? cfg_wr_dev_i :
        assigned_dev_id_o[f*DW +: DW];

      assign mem_next[f] = (hit_cmd && lane_on(cfg_wr_be_i, p_mem)) ?
        cfg_wr_data_i[p_mem] : phys_fn_memory_decode_on_o[f];
      assign init_next[f] = (hit_cmd && lane_on(cfg_wr_be_i, p_init)) ?
        cfg_wr_data_i[p_init] : phys_fn_initiator_allowed_o[f];
      assign vmem_next[f] = (hit_vc && lane_on(cfg_wr_be_i, p_vmem)) ?
        cfg_wr_data_i[p_vmem] : virt_fn_memory_decode_on_o[f];

      assign numvf_next[f*VW +: 8] = nvf_lo ? cfg_wr_data_i[p_nvf +: 8] :
        enabled_virtual_fn_count_o[f*VW +: 8];
      assign numvf_next[f*VW+8 +: 8] = nvf_hi ? cfg_wr_data_i[p_nvf+8 +: 8] :
        enabled_virtual_fn_count_o[f*VW+8 +: 8];

      assign payload_next[f] = (hit_dc && lane_on(cfg_wr_be_i, p_pay)) ?
        cfg_wr_data_i[p_pay +: SW] : payload_reg[f];
      assign rdreq_next[f] = (hit_dc && lane_on(cfg_wr_be_i, p_rdq)) ?
        cfg_wr_data_i[p_rdq +: SW] : rdreq_reg[f];
      assign tag_next[f] = (hit_dc && lane_on(cfg_wr_be_i, p_tag)) ?
        cfg_wr_data_i[p_tag] : wide_tag_allowed_o[f];

      assign timer_next[f] = (hit_dc2 && lane_on(cfg_wr_be_i, p_tmr)) ?
        cfg_wr_data_i[p_tmr] : response_timer_off_o[f];
      assign atomic_next[f] = (hit_dc2 && lane_on(cfg_wr_be_i, p_atm)) ?
        cfg_wr_data_i[p_atm] : atomic_issue_allowed_o[f];

      assign mode_next[f*MW +: MW] = (hit_hint && lane_on(cfg_wr_be_i, p_mode)) ?
        cfg_wr_data_i[p_mode +: MW] : steering_tag_mode_sel_o[f*MW +: MW];
      assign hint_next[f] = (hit_hint && lane_on(cfg_wr_be_i, p_hint)) ?
        cfg_wr_data_i[p_hint] : processing_hint_issue_on_o[f];

      assign unit_next[f*UW +: UW] = (hit_xlat && lane_on(cfg_wr_be_i, p_unit)) ?
        cfg_wr_data_i[p_unit +: UW] : translation_unit_size_o[f*UW +: UW];
      assign xlat_next[f] = (hit_xlat && lane_on(cfg_wr_be_i, p_xlat)) ?
        cfg_wr_data_i[p_xlat] : address_translation_on_o[f];

      // running minimum over the functions that are present
      if (f == 0)
      begin : g_first
        assign payload_min[f] = payload_next[f];
        assign rdreq_min[f] = rdreq_next[f];
      end
      else
      begin : g_rest
        // functions past the count take no part
        wire present = (3'(f) < fn_used);
        assign payload_min[f] = present ? smaller(payload_min[f-1], payload_next[f]) :
          payload_min[f-1];
        assign rdreq_min[f] = present ? smaller(rdreq_min[f-1], rdreq_next[f]) :
          rdreq_min[f-1];
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // routing id capture, all outputs straight from flip-flops
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      assigned_bus_id_o <= {NF{config_status_mirror_pkg::BUS_RST}};
    else
      assigned_bus_id_o <= bus_next;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      assigned_dev_id_o <= {NF{config_status_mirror_pkg::DEV_RST}};
    else
      assigned_dev_id_o <= dev_next;
  end

  // ----------------------------------------------------------------------
  // command and virtualization mirrors
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      phys_fn_memory_decode_on_o <= {NF{config_status_mirror_pkg::BIT_RST}};
    else
      phys_fn_memory_decode_on_o <= mem_next;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      phys_fn_initiator_allowed_o <= {NF{config_status_mirror_pkg::BIT_RST}};
    else
      phys_fn_initiator_allowed_o <= init_next;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      virt_fn_memory_decode_on_o <= {NF{config_status_mirror_pkg::BIT_RST}};
    else
      virt_fn_memory_decode_on_o <= vmem_next;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      enabled_virtual_fn_count_o <= {NF{config_status_mirror_pkg::NUMVF_RST}};
    else
      enabled_virtual_fn_count_o <= numvf_next;
  end

  // ----------------------------------------------------------------------
  // device control mirrors
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      payload_reg <= {NF{config_status_mirror_pkg::PAYLOAD_RST}};
    else
      payload_reg <= payload_next;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      rdreq_reg <= {NF{config_status_mirror_pkg::RDREQ_RST}};
    else
      rdreq_reg <= rdreq_next;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      wide_tag_allowed_o <= {NF{config_status_mirror_pkg::BIT_RST}};
    else
      wide_tag_allowed_o <= tag_next;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      response_timer_off_o <= {NF{config_status_mirror_pkg::BIT_RST}};
    else
      response_timer_off_o <= timer_next;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      atomic_issue_allowed_o <= {NF{config_status_mirror_pkg::BIT_RST}};
    else
      atomic_issue_allowed_o <= atomic_next;
  end

  // ----------------------------------------------------------------------
  // hint and translation mirrors
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      steering_tag_mode_sel_o <= {NF{config_status_mirror_pkg::MODE_RST}};
    else
      steering_tag_mode_sel_o <= mode_next;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      processing_hint_issue_on_o <= {NF{config_status_mirror_pkg::BIT_RST}};
    else
      processing_hint_issue_on_o <= hint_next;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      translation_unit_size_o <= {NF{config_status_mirror_pkg::UNIT_RST}};
    else
      translation_unit_size_o <= unit_next;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      address_translation_on_o <= {NF{config_status_mirror_pkg::BIT_RST}};
    else
      address_translation_on_o <= xlat_next;
  end

  // ----------------------------------------------------------------------
  // limits over the functions present
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      payload_limit_o <= config_status_mirror_pkg::PAYLOAD_RST;
    else
      payload_limit_o <= payload_min[NF-1];
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      read_request_limit_o <= config_status_mirror_pkg::RDREQ_RST;
    else
      read_request_limit_o <= rdreq_min[NF-1];
  end

endmodule

// *** inc/config_status_mirror_pkg.sv ***
package config_status_mirror_pkg;

  // ----------------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------------
  localparam int NUM_FN = 4;
  localparam int FN_W = 2;
  localparam int IDX_W = 10;

  // ----------------------------------------------------------------------
  // dword index of each mirrored register in a function's config space
  // ----------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_CMD = 10'h001;
  localparam logic [IDX_W-1:0] IDX_DEV_CTL = 10'h01e;
  localparam logic [IDX_W-1:0] IDX_DEV_CTL2 = 10'h026;
  localparam logic [IDX_W-1:0] IDX_VIRT_CTL = 10'h042;
  localparam logic [IDX_W-1:0] IDX_VIRT_NUMVF = 10'h044;
  localparam logic [IDX_W-1:0] IDX_HINT_CTL = 10'h052;
  localparam logic [IDX_W-1:0] IDX_XLAT_CTL = 10'h060;

  // ----------------------------------------------------------------------
  // field positions within the written dword
  // ----------------------------------------------------------------------
  localparam int CMD_MEM_BIT = 1;
  localparam int CMD_INIT_BIT = 2;
  localparam int DC_PAYLOAD_LSB = 5;
  localparam int DC_WIDE_TAG_BIT = 8;
  localparam int DC_RDREQ_LSB = 12;
  localparam int DC2_TIMER_OFF_BIT = 4;
  localparam int DC2_ATOMIC_BIT = 6;
  localparam int VIRT_MEM_BIT = 3;
  localparam int NUMVF_LSB = 0;
  localparam int HINT_MODE_LSB = 0;
  localparam int HINT_EN_BIT = 8;
  localparam int XLAT_UNIT_LSB = 16;
  localparam int XLAT_EN_BIT = 31;

  // ----------------------------------------------------------------------
  // field widths and values after reset
  // ----------------------------------------------------------------------
  localparam int BUS_W = 8;
  localparam int DEV_W = 5;
  localparam int SIZE_W = 3;
  localparam int NUMVF_W = 16;
  localparam int MODE_W = 2;
  localparam int UNIT_W = 5;
  localparam logic [BUS_W-1:0] BUS_RST = 8'h00;
  localparam logic [DEV_W-1:0] DEV_RST = 5'h00;
  localparam logic [SIZE_W-1:0] PAYLOAD_RST = 3'h0;
  localparam logic [SIZE_W-1:0] RDREQ_RST = 3'h2;
  localparam logic [NUMVF_W-1:0] NUMVF_RST = 16'h0000;
  localparam logic [MODE_W-1:0] MODE_RST = 2'h0;
  localparam logic [UNIT_W-1:0] UNIT_RST = 5'h00;
  localparam logic BIT_RST = 1'b0;

endpackage

// *** testbench/config_status_mirror_properties.sv ***
`timescale 1ns/100ps
module config_status_mirror_properties (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic cfg_wr_valid_i,
  input wire logic [1:0] cfg_wr_fn_i,
  input wire logic [9:0] cfg_wr_index_i,
  input wire logic [3:0] cfg_wr_be_i,
  input wire logic [31:0] cfg_wr_data_i,
  input wire logic [7:0] cfg_wr_bus_i,
  input wire logic [4:0] cfg_wr_dev_i,
  input wire logic ari_on_i,
  input wire logic [2:0] fn_count_i,
  input wire logic [31:0] assigned_bus_id_o,
  input wire logic [19:0] assigned_dev_id_o,
  input wire logic [3:0] phys_fn_memory_decode_on_o,
  input wire logic [3:0] wide_tag_allowed_o,
  input wire logic [3:0] address_translation_on_o,
  input wire logic [2:0] payload_limit_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // write to one register with the byte that holds the field enabled
  sequence s_wr(idx, b);
    cfg_wr_valid_i && cfg_wr_index_i == idx && cfg_wr_be_i[b];
  endsequence
  AST_BUS_CAPTURE: assert property (
    cfg_wr_valid_i |=> assigned_bus_id_o[8*$past(cfg_wr_fn_i) +: 8] == $past(cfg_wr_bus_i))
    else $error("bus number not captured");
  AST_DEV_CAPTURE: assert property (
    cfg_wr_valid_i && !ari_on_i |=> assigned_dev_id_o[5*$past(cfg_wr_fn_i) +: 5] == $past(cfg_wr_dev_i))
    else $error("device number not captured");
  AST_DEV_ARI_HOLD: assert property (
    cfg_wr_valid_i && ari_on_i |=> $stable(assigned_dev_id_o))
    else $error("device number moved under alternative routing");
  AST_MEM_BIT: assert property (
    s_wr(10'h001, 0) |=> phys_fn_memory_decode_on_o[$past(cfg_wr_fn_i)] == $past(cfg_wr_data_i[1]))
    else $error("memory decode bit wrong");
  AST_WIDE_TAG: assert property (
    s_wr(10'h01e, 1) |=> wide_tag_allowed_o[$past(cfg_wr_fn_i)] == $past(cfg_wr_data_i[8]))
    else $error("wide tag bit wrong");
  AST_XLAT_EN: assert property (
    s_wr(10'h060, 3) |=> address_translation_on_o[$past(cfg_wr_fn_i)] == $past(cfg_wr_data_i[31]))
    else $error("translation enable wrong");
  AST_PAYLOAD_SOLE: assert property (
    s_wr(10'h01e, 0) ##0 (cfg_wr_fn_i == 2'h0 && fn_count_i <= 3'h1)
    |=> payload_limit_o == $past(cfg_wr_data_i[7:5]))
    else $error("payload limit not taken from function 0");
  AST_BITS_HOLD: assert property (
    !cfg_wr_valid_i [*2] |=> $stable({phys_fn_memory_decode_on_o, wide_tag_allowed_o,
    address_translation_on_o, assigned_bus_id_o}))
    else $error("mirrored bits moved without a write");
endmodule
bind config_status_mirror config_status_mirror_properties config_status_mirror_properties_inst (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .cfg_wr_valid_i(cfg_wr_valid_i),
  .cfg_wr_fn_i(cfg_wr_fn_i), .cfg_wr_index_i(cfg_wr_index_i), .cfg_wr_be_i(cfg_wr_be_i),
  .cfg_wr_data_i(cfg_wr_data_i), .cfg_wr_bus_i(cfg_wr_bus_i), .cfg_wr_dev_i(cfg_wr_dev_i),
  .ari_on_i(ari_on_i), .fn_count_i(fn_count_i), .assigned_bus_id_o(assigned_bus_id_o),
  .assigned_dev_id_o(assigned_dev_id_o), .phys_fn_memory_decode_on_o(phys_fn_memory_decode_on_o),
  .wide_tag_allowed_o(wide_tag_allowed_o), .address_translation_on_o(address_translation_on_o),
  .payload_limit_o(payload_limit_o));

// *** testbench/app_consumer_model.sv ***
`timescale 1ns/100ps
module app_consumer_model (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [2:0] payload_limit_i,
  input wire logic [3:0] initiator_allowed_i,
  output logic [14:0] payload_bytes_o
);
  // largest request the application may issue; none while no function may initiate
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      payload_bytes_o <= 15'h0000;
    else
      payload_bytes_o <= (|initiator_allowed_i) ? (15'h0080 << payload_limit_i) : 15'h0000;
  end
endmodule

// *** testbench/test_config_status_mirror.sv ***
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin n_compared++; if ((ex) !== (gt)) begin fails++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end
module test_config_status_mirror;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, cfg_wr_valid_i = 1'b0, ari_on_i = 1'b0;
  logic [1:0] cfg_wr_fn_i = 2'h0;
  logic [9:0] cfg_wr_index_i = 10'h000;
  logic [3:0] cfg_wr_be_i = 4'h0;
  logic [31:0] cfg_wr_data_i = 32'h0, seed = 32'h45, r;
  logic [7:0] cfg_wr_bus_i = 8'h00, steering_tag_mode_sel_o, bus_m [4];
  logic [4:0] cfg_wr_dev_i = 5'h00, dev_m [4];
  logic [2:0] fn_count_i = 3'h4, payload_limit_o, read_request_limit_o;
  logic [31:0] assigned_bus_id_o, img [4][7];
  logic [19:0] assigned_dev_id_o, translation_unit_size_o;
  logic [63:0] enabled_virtual_fn_count_o;
  logic [3:0] phys_fn_memory_decode_on_o, phys_fn_initiator_allowed_o, virt_fn_memory_decode_on_o;
  logic [3:0] wide_tag_allowed_o, response_timer_off_o, atomic_issue_allowed_o;
  logic [3:0] processing_hint_issue_on_o, address_translation_on_o;
  logic [14:0] payload_bytes, pb_exp = 15'h0000;
  logic [9:0] idx_tab [8] = '{10'h001, 10'h01e, 10'h026, 10'h042, 10'h044, 10'h052, 10'h060, 10'h3ff};
  int fails = 0, n_compared = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  config_status_mirror config_status_mirror_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .cfg_wr_valid_i(cfg_wr_valid_i), .cfg_wr_fn_i(cfg_wr_fn_i), .cfg_wr_index_i(cfg_wr_index_i),
    .cfg_wr_be_i(cfg_wr_be_i), .cfg_wr_data_i(cfg_wr_data_i), .cfg_wr_bus_i(cfg_wr_bus_i),
    .cfg_wr_dev_i(cfg_wr_dev_i), .ari_on_i(ari_on_i), .fn_count_i(fn_count_i),
    .assigned_bus_id_o(assigned_bus_id_o), .assigned_dev_id_o(assigned_dev_id_o),
    .phys_fn_memory_decode_on_o(phys_fn_memory_decode_on_o),
    .phys_fn_initiator_allowed_o(phys_fn_initiator_allowed_o),
    .virt_fn_memory_decode_on_o(virt_fn_memory_decode_on_o),
    .enabled_virtual_fn_count_o(enabled_virtual_fn_count_o), .payload_limit_o(payload_limit_o),
    .read_request_limit_o(read_request_limit_o), .wide_tag_allowed_o(wide_tag_allowed_o),
    .response_timer_off_o(response_timer_off_o), .atomic_issue_allowed_o(atomic_issue_allowed_o),
    .steering_tag_mode_sel_o(steering_tag_mode_sel_o),
    .processing_hint_issue_on_o(processing_hint_issue_on_o),
    .translation_unit_size_o(translation_unit_size_o),
    .address_translation_on_o(address_translation_on_o));
  app_consumer_model app_consumer_model_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .payload_limit_i(payload_limit_o), .initiator_allowed_i(phys_fn_initiator_allowed_o),
    .payload_bytes_o(payload_bytes));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // minimum of a device control field over the functions present
  function automatic logic [2:0] lim(input int sh);
    logic [2:0] m;
    int n;
    n = (fn_count_i == 3'h0) ? 1 : int'(fn_count_i);
    m = img[0][1][sh +: 3];
    for (int f = 1; f < n; f++)
      if (img[f][1][sh +: 3] < m) m = img[f][1][sh +: 3];
    return m;
  endfunction
  task automatic check_all();
    logic [31:0] eb;
    logic [19:0] ed, eu;
    logic [63:0] ev;
    logic [7:0] em;
    logic [3:0] e [8];
    for (int f = 0; f < 4; f++)
    begin
      eb[8*f +: 8] = bus_m[f];
      ed[5*f +: 5] = dev_m[f];
      ev[16*f +: 16] = img[f][4][15:0];
      em[2*f +: 2] = img[f][5][1:0];
      eu[5*f +: 5] = img[f][6][20:16];
      e[0][f] = img[f][0][1];
      e[1][f] = img[f][0][2];
      e[2][f] = img[f][3][3];
      e[3][f] = img[f][1][8];
      e[4][f] = img[f][2][4];
      e[5][f] = img[f][2][6];
      e[6][f] = img[f][5][8];
      e[7][f] = img[f][6][31];
    end
    `CHK("bus", eb, assigned_bus_id_o)
    `CHK("dev", ed, assigned_dev_id_o)
    `CHK("mem", e[0], phys_fn_memory_decode_on_o)
    `CHK("init", e[1], phys_fn_initiator_allowed_o)
    `CHK("vmem", e[2], virt_fn_memory_decode_on_o)
    `CHK("numvf", ev, enabled_virtual_fn_count_o)
    `CHK("payload", lim(5), payload_limit_o)
    `CHK("rdreq", lim(12), read_request_limit_o)
    `CHK("wtag", e[3], wide_tag_allowed_o)
    `CHK("toff", e[4], response_timer_off_o)
    `CHK("atomic", e[5], atomic_issue_allowed_o)
    `CHK("mode", em, steering_tag_mode_sel_o)
    `CHK("hint", e[6], processing_hint_issue_on_o)
    `CHK("unit", eu, translation_unit_size_o)
    `CHK("xlat", e[7], address_translation_on_o)
    `CHK("bytes", pb_exp, payload_bytes)
    pb_exp = (|e[1]) ? (15'h0080 << lim(5)) : 15'h0000;
  endtask
  task automatic tick();
    @(posedge clk_sys_i);
    #1;
    check_all();
  endtask
  task automatic wr(input logic [1:0] f, input logic [9:0] ix, input logic [3:0] be,
                    input logic [31:0] d, input logic [7:0] b, input logic [4:0] dv);
    {cfg_wr_valid_i, cfg_wr_fn_i, cfg_wr_index_i, cfg_wr_be_i} = {1'b1, f, ix, be};
    {cfg_wr_data_i, cfg_wr_bus_i, cfg_wr_dev_i} = {d, b, dv};
    bus_m[f] = b;
    if (!ari_on_i) dev_m[f] = dv;
    for (int k = 0; k < 7; k++)
      for (int y = 0; y < 4; y++)
        if (idx_tab[k] == ix && be[y]) img[f][k][8*y +: 8] = d[8*y +: 8];
    tick();
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    foreach (img[f, k]) img[f][k] = (k == 1) ? 32'h00002000 : 32'h00000000;
    foreach (bus_m[f]) {bus_m[f], dev_m[f]} = 13'h0000;
    repeat (4) @(posedge clk_sys_i);
    #1 rst_i = 1'b0;
    tick();
    fn_count_i = 3'h2;
    wr(2'h1, 10'h001, 4'h1, 32'h6, 8'h12, 5'h03);
    wr(2'h0, 10'h01e, 4'h1, 32'h40, 8'h12, 5'h03);
    wr(2'h1, 10'h01e, 4'h1, 32'h0, 8'h12, 5'h03);
    fn_count_i = 3'h0;
    for (int k = 0; k < 8; k++)
      for (int f = 0; f < 4; f++)
        wr(f[1:0], idx_tab[k], 4'hf, 32'hffffffff, 8'hff, 5'h1f);
    for (int k = 0; k < 8; k++)
      wr(2'h2, idx_tab[k], 4'h0, 32'h0, 8'h5a, 5'h0a);
    for (int i = 0; i < 600; i++)
    begin
      r = xs();
      ari_on_i = r[1];
      fn_count_i = 3'(r[4:2] % 5);
      if (r[0]) wr(r[6:5], idx_tab[r[9:7]], r[13:10], xs(), r[21:14], r[26:22]);
      else
      begin
        cfg_wr_valid_i = 1'b0;
        tick();
      end
    end
    print_verdict();
  end
endmodule
